// *** switch_global_cfg.svh ***
`ifndef SWITCH_GLOBAL_CFG_SVH
`define SWITCH_GLOBAL_CFG_SVH

// ==========================================================
// Register indices and byte addresses (index times four).
// ==========================================================
`define IDX_LOOP 6'h0B
`define IDX_PRIO_LO 6'h0C
`define IDX_PRIO_HI 6'h0D
`define IDX_UNKNOWN 6'h0E
`define ADDR_LOOP ({`IDX_LOOP, 2'h0})
`define ADDR_PRIO_LO ({`IDX_PRIO_LO, 2'h0})
`define ADDR_PRIO_HI ({`IDX_PRIO_HI, 2'h0})
`define ADDR_UNKNOWN ({`IDX_UNKNOWN, 2'h0})

// ==========================================================
// Field positions.
// ==========================================================
`define BIT_LED_HI 7
`define BIT_DROP 5
`define BIT_LOOP_HI 3
`define BIT_LOOP_LO 2
`define BIT_LED_LO 1
`define BIT_TPID 0
`define BIT_UNK_EN 7

// ==========================================================
// Reset values.
// ==========================================================
`define RST_LOOP 8'h08
`define RST_PRIO_LO 8'h50
`define RST_PRIO_HI 8'hFA
`define RST_UNKNOWN 8'h07

`endif

// *** switch_global_pkg.sv ***
package switch_global_pkg;

  typedef enum logic [2:0] {
    LP_TP_SIDE = 3'h1,
    LP_MAC = 3'h2,
    LP_OPTICAL = 3'h4
  } loop_point_type;

  typedef enum logic [1:0] {
    ST_STRAP = 2'h1,
    ST_RUN = 2'h2
  } state_type;

  typedef struct packed {
    logic led_mode_sel_hi;
    logic led_mode_sel_lo;
    logic errored_frame_drop_strap;
    logic loop_point_strap;
  } strap_type;

  typedef struct packed {
    logic valid;
    logic mgmt;
    logic crc_err;
    logic undersize;
    logic oversize;
  } frame_info_type;

  typedef struct packed {
    logic valid;
    logic [2:0] pcp;
  } tag_req_type;

  typedef struct packed {
    logic valid;
    logic [2:0] normal_ports;
  } unk_req_type;

endpackage : switch_global_pkg

// *** switch_global_ctrl.sv ***
`timescale 1ns/10ps
`include "switch_global_cfg.svh"

// Operation
// (R1) With drop enabled in loopback, management and CRC, undersize or oversize frames are dropped, good ones looped.
// (R2) With drop disabled in loopback, only management frames are dropped and every Ethernet frame is looped.
// (R3) The two position bits pick the loop point: 00 twisted-pair side, 10 MAC, x1 optical side.
// (R4) After reset the upper position bit is one and the lower, drop and both LED bits come from straps.
// (R5) The LED mode is the two-bit selector formed by bit 7 and bit 1 of the loopback register.
// (R6) Software keeps the testing-mode bit 4 at zero.
// (R7) Bit 0 of the loopback register enables the special tag-identifier forwarding mode.
// (R8) Tags 0 to 3 take their priority from the two-bit fields of the low map register.
// (R9) Tags 4 to 7 take their priority from the two-bit fields of the high map register.
// (R10) With bit 7 of the steering register set, unknown-destination packets go to the ports in bits 2:0.
// (R11) Port field bit 2 is the third port, bit 1 the second, bit 0 the first; it resets to all ones.
// (R12) Software leaves the reserved bits at their defaults.
// (R13) With steering disabled, unknown-destination packets follow normal forwarding.

module switch_global_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire switch_global_pkg::strap_type i_strap,
  input wire logic i_mc_loop_active,
  input wire switch_global_pkg::frame_info_type i_frame,
  output logic o_loop_fwd,
  output logic o_loop_drop,
  input wire switch_global_pkg::tag_req_type i_tag,
  output logic o_prio_valid,
  output logic [1:0] o_prio,
  input wire switch_global_pkg::unk_req_type i_unk,
  output logic o_unk_valid,
  output logic [2:0] o_unk_ports,
  output logic [1:0] o_led_mode,
  output switch_global_pkg::loop_point_type o_loop_point,
  output logic o_special_tpid_en
);
  import switch_global_pkg::*;

  // ==========================================================
  // Register bus slave.
  // ==========================================================
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] loop_q;
  logic [7:0] loop_d;
  logic [7:0] prio_lo_q;
  logic [7:0] prio_hi_q;
  logic [7:0] unk_q;
  state_type st_q;

  wire req = i_wb_cyc & i_wb_stb;
  wire hit_loop = (i_wb_adr == `ADDR_LOOP);
  wire hit_prio_lo = (i_wb_adr == `ADDR_PRIO_LO);
  wire hit_prio_hi = (i_wb_adr == `ADDR_PRIO_HI);
  wire hit_unk = (i_wb_adr == `ADDR_UNKNOWN);

  // The write lands on the edge where the master sees ack, so a
  // request that is dropped early never changes the registers.
  wire wr_lane0 = req & ack_q & i_wb_we & i_wb_sel[0];
  wire wr_loop = wr_lane0 & hit_loop;
  wire wr_prio_lo = wr_lane0 & hit_prio_lo;
  wire wr_prio_hi = wr_lane0 & hit_prio_hi;
  wire wr_unk = wr_lane0 & hit_unk;

  // Unmapped addresses are still acknowledged and read as zero.
  wire [7:0] rd_mux = ({8{hit_loop}} & loop_q) |
                      ({8{hit_prio_lo}} & prio_lo_q) |
                      ({8{hit_prio_hi}} & prio_hi_q) |
                      ({8{hit_unk}} & unk_q);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'h0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rdat_q <= {24'h0, rd_mux};
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ==========================================================
  // Strap capture.
  // ==========================================================
  // Straps are caught on the first edge after reset release,
  // since an asynchronous reset may only load constants.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_STRAP;
    end else begin
      unique case (st_q)
        ST_STRAP: begin
          st_q <= ST_RUN;
        end
        ST_RUN: begin
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_STRAP;
        end
      endcase
    end
  end

  always_comb begin
    loop_d = loop_q;
    if (st_q == ST_STRAP) begin
      loop_d[`BIT_LED_HI] = i_strap.led_mode_sel_hi; // [R4]
      loop_d[`BIT_LED_LO] = i_strap.led_mode_sel_lo; // [R4]
      loop_d[`BIT_DROP] = i_strap.errored_frame_drop_strap; // [R4]
      loop_d[`BIT_LOOP_LO] = i_strap.loop_point_strap; // [R4]
    end else if (wr_loop) begin
      loop_d = i_wb_dat[7:0];
    end
  end

  // ==========================================================
  // Configuration registers.
  // ==========================================================
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loop_q <= `RST_LOOP; // [R4]
      prio_lo_q <= `RST_PRIO_LO;
      prio_hi_q <= `RST_PRIO_HI;
      unk_q <= `RST_UNKNOWN; // [R11]
    end else begin
      loop_q <= loop_d;
      if (wr_prio_lo) begin
        prio_lo_q <= i_wb_dat[7:0];
      end
      if (wr_prio_hi) begin
        prio_hi_q <= i_wb_dat[7:0];
      end
      if (wr_unk) begin
        unk_q <= i_wb_dat[7:0];
      end
    end
  end

  // ==========================================================
  // Static controls.
  // ==========================================================
  wire lp_lo = loop_q[`BIT_LOOP_LO];
  wire lp_hi = loop_q[`BIT_LOOP_HI];

  // The lower position bit overrides the upper one.
  assign o_loop_point = lp_lo ? LP_OPTICAL : (lp_hi ? LP_MAC : LP_TP_SIDE); // [R3]
  assign o_led_mode = {loop_q[`BIT_LED_HI], loop_q[`BIT_LED_LO]}; // [R5]
  assign o_special_tpid_en = loop_q[`BIT_TPID]; // [R7]

  // ==========================================================
  // Loopback frame filter.
  // ==========================================================
  wire frame_in = i_frame.valid & i_mc_loop_active;
  wire frame_bad = i_frame.crc_err | i_frame.undersize | i_frame.oversize;
  wire drop_bad = loop_q[`BIT_DROP] & frame_bad; // [R1]
  wire frame_drop = i_frame.mgmt | drop_bad; // [R1] [R2]
  logic fwd_q;
  logic drop_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fwd_q <= 1'h0;
      drop_q <= 1'h0;
    end else begin
      fwd_q <= frame_in & ~frame_drop; // [R1] [R2]
      drop_q <= frame_in & frame_drop; // [R1] [R2]
    end
  end

  assign o_loop_fwd = fwd_q;
  assign o_loop_drop = drop_q;

  // ==========================================================
  // Tag to priority lookup.
  // ==========================================================
  wire [7:0] prio_map = i_tag.pcp[2] ? prio_hi_q : prio_lo_q; // [R8] [R9]
  wire [1:0] prio_sel = i_tag.pcp[1:0];
  wire [1:0] prio_d = prio_map[{prio_sel, 1'h0} +: 2]; // [R8] [R9]
  logic prio_valid_q;
  logic [1:0] prio_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prio_valid_q <= 1'h0;
      prio_q <= 2'h0;
    end else begin
      prio_valid_q <= i_tag.valid;
      if (i_tag.valid) begin
        prio_q <= prio_d;
      end
    end
  end

  assign o_prio_valid = prio_valid_q;
  assign o_prio = prio_q;

  // ==========================================================
  // Unknown-destination steering.
  // ==========================================================
  wire unk_en = unk_q[`BIT_UNK_EN];
  // Bit n of the field is port n plus one.
  wire [2:0] unk_d = unk_en ? unk_q[2:0] : i_unk.normal_ports; // [R10] [R11] [R13]
  logic unk_valid_q;
  logic [2:0] unk_ports_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unk_valid_q <= 1'h0;
      unk_ports_q <= 3'h0;
    end else begin
      unk_valid_q <= i_unk.valid;
      if (i_unk.valid) begin
        unk_ports_q <= unk_d;
      end
    end
  end

  assign o_unk_valid = unk_valid_q;
  assign o_unk_ports = unk_ports_q;

  // ==========================================================
  // Assertions.
  // ==========================================================
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_drop_bad_frame: assert property ( // [R1]
    (frame_in && loop_q[`BIT_DROP] && frame_bad)
      |=> (o_loop_drop && !o_loop_fwd))
    else $error("Errored frame looped back with drop enabled.");

  a_loop_all_frames: assert property ( // [R2]
    (frame_in && !loop_q[`BIT_DROP] && !i_frame.mgmt)
      |=> (o_loop_fwd && !o_loop_drop))
    else $error("Ethernet frame not looped with drop disabled.");

  a_mgmt_dropped: assert property ( // [R2]
    (frame_in && i_frame.mgmt) |=> o_loop_drop)
    else $error("Management frame was not dropped in loopback.");

  a_loop_point_opt: assert property ( // [R3]
    (wr_loop && i_wb_dat[`BIT_LOOP_LO])
      |=> (o_loop_point == LP_OPTICAL))
    else $error("Lower position bit did not select the optical side.");

  a_loop_point_mac: assert property ( // [R3]
    (wr_loop && (i_wb_dat[3:2] == 2'h2))
      |=> (o_loop_point == LP_MAC))
    else $error("Position 10 did not select the MAC.");

  a_strap_capture: assert property ( // [R4]
    (st_q == ST_STRAP)
      |=> (lp_hi && (lp_lo == $past(i_strap.loop_point_strap))
           && (loop_q[`BIT_DROP] == $past(i_strap.errored_frame_drop_strap))
           && (o_led_mode == {$past(i_strap.led_mode_sel_hi), $past(i_strap.led_mode_sel_lo)})))
    else $error("Straps not captured after reset.");

  a_led_write: assert property ( // [R5]
    wr_loop |=> (o_led_mode == {$past(i_wb_dat[7]), $past(i_wb_dat[1])}))
    else $error("LED mode does not follow bits 7 and 1.");

  a_tpid_write: assert property ( // [R7]
    wr_loop |=> (o_special_tpid_en == $past(i_wb_dat[0])))
    else $error("Tag-identifier mode does not follow bit 0.");

  a_prio_tag0: assert property ( // [R8]
    (i_tag.valid && (i_tag.pcp == 3'h0) && !wr_prio_lo)
      |=> (o_prio_valid && (o_prio == prio_lo_q[1:0])))
    else $error("Tag 0 priority differs from its map field.");

  a_prio_tag7: assert property ( // [R9]
    (i_tag.valid && (i_tag.pcp == 3'h7) && !wr_prio_hi)
      |=> (o_prio_valid && (o_prio == prio_hi_q[7:6])))
    else $error("Tag 7 priority differs from its map field.");

  a_unk_steered: assert property ( // [R10]
    (i_unk.valid && unk_en && !wr_unk)
      |=> (o_unk_valid && (o_unk_ports == unk_q[2:0])))
    else $error("Unknown packet not sent to the selected ports.");

  a_unk_reset: assert property ( // [R11]
    (st_q == ST_STRAP) |-> (unk_q[2:0] == 3'h7))
    else $error("Port field did not reset to all ones.");

  a_unk_normal: assert property ( // [R13]
    (i_unk.valid && !unk_en)
      |=> (o_unk_ports == $past(i_unk.normal_ports)))
    else $error("Normal forwarding not kept with steering disabled.");

  a_unk_valid: assert property (
    i_unk.valid |=> o_unk_valid)
    else $error("Unknown-destination lookup gave no valid pulse.");

  a_loop_point_tp: assert property ( // [R3]
    (wr_loop && (i_wb_dat[3:2] == 2'h0))
      |=> (o_loop_point == LP_TP_SIDE))
    else $error("Position 00 did not select the twisted-pair side.");

  a_prio_tag3: assert property ( // [R8]
    (i_tag.valid && (i_tag.pcp == 3'h3) && !wr_prio_lo)
      |=> (o_prio_valid && (o_prio == prio_lo_q[7:6])))
    else $error("Tag 3 priority differs from its map field.");

  a_prio_tag4: assert property ( // [R9]
    (i_tag.valid && (i_tag.pcp == 3'h4) && !wr_prio_hi)
      |=> (o_prio_valid && (o_prio == prio_hi_q[1:0])))
    else $error("Tag 4 priority differs from its map field.");

  a_prio_lo_write: assert property ( // [R8]
    wr_prio_lo |=> (prio_lo_q == $past(i_wb_dat[7:0])))
    else $error("Low priority map did not take the written byte.");

  a_prio_hi_write: assert property ( // [R9]
    wr_prio_hi |=> (prio_hi_q == $past(i_wb_dat[7:0])))
    else $error("High priority map did not take the written byte.");

  a_unk_write: assert property ( // [R11]
    wr_unk |=> (unk_q == $past(i_wb_dat[7:0])))
    else $error("Steering register did not take the written byte.");

  // A second acknowledge in a row would let one request complete twice.
  a_ack_pulse: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("Acknowledge stood for more than one cycle.");

  a_read_upper_zero: assert property (
    o_wb_ack |-> (o_wb_dat[31:8] == 24'h0))
    else $error("Read data carries bits above the register byte.");

  // Outside loopback mode the filter must stay silent.
  a_loop_idle: assert property (
    !frame_in |=> (!o_loop_fwd && !o_loop_drop))
    else $error("Loopback filter pulsed without a looped frame.");

endmodule : switch_global_ctrl

// *** switch_global_ctrl_bench.sv ***
`timescale 1ns/10ps
`include "switch_global_cfg.svh"

module switch_global_ctrl_bench;
  import switch_global_pkg::*;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, act = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wdat = 0, q;
  strap_type strap = 4'hB;
  frame_info_type frm = '0;
  tag_req_type tag = '0;
  unk_req_type unk = '0;
  logic [31:0] rdat;
  logic ack, fwd, drp, pv, uv, tpid;
  logic [1:0] prio, led;
  logic [2:0] ports, np;
  loop_point_type lp;
  int mismatches = 0, tests_run = 0;
  logic [15:0] lf = 16'h9DD8;
  logic [7:0] m [4];
  logic d;

  switch_global_ctrl dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_strap(strap), .i_mc_loop_active(act), .i_frame(frm), .o_loop_fwd(fwd), .o_loop_drop(drp),
    .i_tag(tag), .o_prio_valid(pv), .o_prio(prio), .i_unk(unk), .o_unk_valid(uv),
    .o_unk_ports(ports), .o_led_mode(led), .o_loop_point(lp), .o_special_tpid_en(tpid));

  initial forever #2 clk = ~clk;

  // ==========================================================
  // Shared tasks.
  // ==========================================================
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  // The request is held until ack is sampled high, so no cycle count is assumed.
  task wb(input logic w, input logic [7:0] a, input logic [7:0] dv, input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; wdat <= {24'h0, dv};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      mismatches++;
      end_of_test;
    end
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
  endtask : wb

  task wr(input int i, input logic [7:0] dv);
    m[i] = dv;
    wb(1, {6'h0B + i[5:0], 2'h0}, dv, 4'hF);
  endtask : wr

  task check_all;
    for (int i = 0; i < 4; i++) begin
      wb(0, {6'h0B + i[5:0], 2'h0}, 8'h00, 4'hF);
      chk("register", {24'h0, m[i]}, q);
    end
    chk("led mode", {m[0][7], m[0][1]}, led);
    chk("loop point", m[0][2] ? 3'h4 : (m[0][3] ? 3'h2 : 3'h1), lp);
    chk("tpid enable", m[0][0], tpid);
  endtask : check_all

  task pulse;
    @(posedge clk);
    tag <= '0; unk <= '0; frm <= '0;
    @(posedge clk);
  endtask : pulse

  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    m[0] = {strap[3], 1'b0, strap[1], 1'b0, 1'b1, strap[0], strap[2], 1'b0};
    m[1] = `RST_PRIO_LO;
    m[2] = `RST_PRIO_HI;
    m[3] = `RST_UNKNOWN;
    check_all;
    for (int r = 0; r < 6; r++) begin
      lf = nx(lf);
      wr(0, (lf[7:0] & 8'hA3) | {2'b0, r[1], 1'b0, r[1:0], 2'b0});
      lf = nx(lf);
      wr(1, lf[7:0]);
      wr(2, lf[15:8]);
      lf = nx(lf);
      wr(3, (lf[7:0] & 8'h07) | {r[0], 7'h0});
      check_all;
      for (int p = 0; p < 8; p++) begin
        tag <= {1'b1, p[2:0]};
        pulse;
        chk("priority", {1'b1, 2'(m[1 + p / 4] >> (2 * (p % 4)))}, {pv, prio});
      end
      np = lf[10:8];
      unk <= {1'b1, np};
      pulse;
      chk("unknown ports", {1'b1, m[3][7] ? m[3][2:0] : np}, {uv, ports});
      for (int k = 0; k < 32; k++) begin
        act <= k[4];
        frm <= {1'b1, k[3:0]};
        pulse;
        d = k[3] | (m[0][5] & |k[2:0]);
        chk("loop filter", k[4] ? {~d, d} : 2'b00, {fwd, drp});
      end
    end
    wb(1, 8'h2C, 8'hFF, 4'h0);
    wb(1, 8'h28, 8'hFF, 4'hF);
    wb(0, 8'h28, 8'h00, 4'hF);
    chk("unmapped read", 32'h0, q);
    check_all;
    end_of_test;
  end
endmodule : switch_global_ctrl_bench
